/* File: common/ebl_defs.svh */
// Constants of the boot loader and memory map block.
`ifndef EBL_DEFS_SVH
`define EBL_DEFS_SVH
`define EBL_PRAM_WORDS 4096
`define EBL_PRAM_TOP 16'h0FFF
`define EBL_PRAM_LAST 12'hFFF
`define EBL_CLK_KHZ 25000
`define EBL_SLOW_KHZ 500
`define EBL_FAST_KHZ 1000
`define EBL_XO_4M 3'h0
`define EBL_XO_8M 3'h1
`define EBL_XO_12M 3'h2
`define EBL_XO_16M 3'h3
`define EBL_XO_KHZ_4 4000
`define EBL_XO_KHZ_8 8000
`define EBL_XO_KHZ_12 12000
`define EBL_XO_KHZ_16 16000
`define EBL_XO_KHZ_20 20000
`define EBL_VER_MSB 7
`define EBL_VER_LSB 6
`define EBL_VERSION 2'h0
`define EBL_SPEED_BIT 3
`define EBL_XO_MSB 2
`define EBL_XO_LSB 0
`define EBL_EE_READ 8'h03
`define EBL_EE_FILL 8'h00
`define EBL_HDR_CFG 9'h000
`define EBL_HDR_OFS 9'h001
`define EBL_ADDR_LAST 9'h002
`define EBL_BITRAM_BASE 8'h20
`define EBL_BANK_MSB 4
`define EBL_BANK_LSB 3
`define EBL_REG_STATUS 8'h00
`define EBL_REG_HEADER 8'h04
`define EBL_REG_CONTROL 8'h08
`define EBL_REG_DIVIDER 8'h0C
`define EBL_CTRL_RESTART 0
`define EBL_RESP_OKAY 2'h0
`define EBL_RESP_SLVERR 2'h2
`define EBL_CAUSE_POR 1'b0
`define EBL_CAUSE_OTHER 1'b1
`endif

/* File: common/ebl_pkg.sv */
// Types of the boot loader and memory map block.
package ebl_pkg;
    typedef logic [7:0] ebl_byte_t;
    typedef enum logic [2:0] {
        ST_BOOT = 3'b000,
        ST_CMD = 3'b001,
        ST_HDR = 3'b010,
        ST_SKIP = 3'b011,
        ST_COPY = 3'b100,
        ST_RUN = 3'b101,
        ST_ERR = 3'b110
    } ebl_state_e;
    typedef struct packed {
        ebl_state_e state;
        logic cause;
        logic done;
        logic ver_err;
        ebl_byte_t hdr0;
        ebl_byte_t hdr1;
        ebl_byte_t hdr2;
        logic [5:0] half;
        logic [5:0] div_cnt;
        logic sck;
        logic mosi;
        logic cs_n;
        ebl_byte_t sh_out;
        ebl_byte_t sh_in;
        logic [2:0] bit_cnt;
        logic busy;
        logic [8:0] idx;
        logic [11:0] wr_addr;
        logic [15:0] left;
        logic ld_we;
        ebl_byte_t ld_data;
        logic core_rst;
        logic miso_s1;
        logic miso_s2;
        logic aw_got;
        logic w_got;
        ebl_byte_t aw_addr;
        logic w_bit0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ebl_state_s;
endpackage

/* File: src/ebl_loader.sv */
// Boot loader from serial EEPROM and the core's memory map.
`timescale 1ns/1ps
`default_nettype none
`include "ebl_defs.svh"
// Functional notes
// - 4 KB program memory at address zero.
// - Program memory readable and writable like RAM.
// - After power-on, load program from EEPROM.
// - Lower 128 bytes: direct and indirect access.
// - Upper 128 RAM bytes: indirect access only.
// - Direct upper addresses select special registers.
// - Four register banks, status word selects.
// - Sixteen bytes after banks are bit-addressable.
// - Special registers at x0/x8 are bit-addressable.
// - Header byte: version, speed, crystal fields.
// - Speed bit caps serial clock rate.
// - Crystal code decodes to 4..20 MHz.
// - Header byte one gives program offset.
// - Header byte two counts 256-byte blocks.
// - Program bytes stored sequentially from zero.
// - Bytes between header and offset ignored.
// - Core runs standard instruction encoding.
// - Instruction timing may differ from classic.
// - Watchdog restart never reloads the program.
module ebl_loader (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic wdog_rst_i,
    output logic core_rst_o,
    output logic spi_sck_o,
    output logic spi_mosi_o,
    output logic spi_cs_n_o,
    input wire logic spi_miso_i,
    input wire logic [15:0] pram_addr_i,
    input wire logic pram_we_i,
    input wire ebl_pkg::ebl_byte_t pram_wdata_i,
    output ebl_pkg::ebl_byte_t pram_rdata_o,
    output logic pram_hit_o,
    input wire logic [7:0] idata_addr_i,
    input wire logic idata_indirect_i,
    input wire logic idata_reg_i,
    input wire logic idata_bit_i,
    input wire logic idata_we_i,
    input wire ebl_pkg::ebl_byte_t idata_wdata_i,
    input wire ebl_pkg::ebl_byte_t program_status_word_i,
    output ebl_pkg::ebl_byte_t idata_rdata_o,
    output logic sfr_sel_o,
    output logic [7:0] sfr_addr_o,
    output logic [2:0] sfr_bit_o,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    import ebl_pkg::*;

    ebl_state_s st;
    ebl_state_s next_st;
    logic byte_done;
    ebl_byte_t rx_byte;
    logic [7:0] eff_addr;
    logic pram_hit;
    ebl_byte_t pram_mem [0:`EBL_PRAM_WORDS-1];
    ebl_byte_t iram [0:255];

    // ************************************************************
    // Helpers
    // ************************************************************

    // Half-period in clocks, rounded up so the clock never runs fast.
    function automatic logic [5:0] half_calc(input int khz, input int lim);
        int q;
        q = (khz + 2 * lim - 1) / (2 * lim);
        return q[5:0];
    endfunction

    // Crystal and speed fields of the first header byte to a divider.
    function automatic logic [5:0] spi_half(input ebl_byte_t cfg);
        int khz;
        int lim;
        case (cfg[`EBL_XO_MSB:`EBL_XO_LSB])
            `EBL_XO_4M: khz = `EBL_XO_KHZ_4;
            `EBL_XO_8M: khz = `EBL_XO_KHZ_8;
            `EBL_XO_12M: khz = `EBL_XO_KHZ_12;
            `EBL_XO_16M: khz = `EBL_XO_KHZ_16;
            default: khz = `EBL_XO_KHZ_20; // Unknown codes take the safe one.
        endcase
        lim = cfg[`EBL_SPEED_BIT] ? `EBL_FAST_KHZ : `EBL_SLOW_KHZ;
        return half_calc(khz, lim);
    endfunction

    // Bit address to byte address: low half in bit RAM, high half in
    // special registers whose low digit is 0 or 8.
    function automatic logic [7:0] bit_byte(input logic [7:0] b);
        bit_byte = b[7] ? {b[7:3], 3'h0} :
            `EBL_BITRAM_BASE + {4'h0, b[6:3]};
    endfunction

    // ************************************************************
    // Loader, register slave and synchroniser
    // ************************************************************

    // A byte ends at the falling edge after its eighth bit.
    assign byte_done = st.busy && st.sck && st.bit_cnt == 3'h7 &&
        st.div_cnt == st.half - 6'h01;
    assign rx_byte = {st.sh_in[6:0], st.miso_s2};

    // Next-state logic of the whole state record; the memories update on their own.
    always_comb begin
        logic tick;
        logic start;
        logic finish;
        logic restart;
        ebl_byte_t tx;
        tick = st.busy && st.div_cnt == st.half - 6'h01;
        start = 1'b0;
        finish = 1'b0;
        restart = 1'b0;
        tx = `EBL_EE_FILL;
        next_st = st;
        next_st.miso_s1 = spi_miso_i;
        next_st.miso_s2 = st.miso_s1;
        next_st.ld_we = 1'b0;
        if (st.ld_we) begin
            next_st.wr_addr = st.wr_addr + 12'h001;
        end
        // Bit engine: sample late in the high half so the two-stage
        // synchroniser has settled on the bit sent at the last fall.
        if (st.busy) begin
            next_st.div_cnt = tick ? 6'h00 : st.div_cnt + 6'h01;
        end
        if (tick && !st.sck) begin
            next_st.sck = 1'b1;
        end
        if (tick && st.sck) begin
            next_st.sck = 1'b0;
            next_st.sh_in = rx_byte;
            if (st.bit_cnt == 3'h7) begin
                next_st.busy = 1'b0;
            end else begin
                next_st.mosi = st.sh_out[6];
                next_st.sh_out = {st.sh_out[6:0], 1'b0};
                next_st.bit_cnt = st.bit_cnt + 3'h1;
            end
        end
        // Register slave: write address and data in either order.
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            next_st.aw_got = 1'b1;
            next_st.aw_addr = {s_axi_awaddr_i[7:2], 2'h0};
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            next_st.w_got = 1'b1;
            next_st.w_bit0 = s_axi_wstrb_i[0] &&
                s_axi_wdata_i[`EBL_CTRL_RESTART];
        end
        if (st.aw_got && st.w_got) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = `EBL_RESP_OKAY;
            case (st.aw_addr)
                `EBL_REG_CONTROL: restart = st.w_bit0;
                `EBL_REG_STATUS, `EBL_REG_HEADER, `EBL_REG_DIVIDER: begin
                    restart = 1'b0;
                end
                default: next_st.bresp = `EBL_RESP_SLVERR;
            endcase
        end else if (st.bvalid && s_axi_bready_i) begin
            next_st.bvalid = 1'b0;
        end
        if (s_axi_arvalid_i && !st.rvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = `EBL_RESP_OKAY;
            case ({s_axi_araddr_i[7:2], 2'h0})
                `EBL_REG_STATUS: begin
                    next_st.rdata = {29'h0, st.cause, st.ver_err, st.done};
                end
                `EBL_REG_HEADER: begin
                    next_st.rdata = {8'h00, st.hdr2, st.hdr1, st.hdr0};
                end
                `EBL_REG_DIVIDER: next_st.rdata = {26'h0, st.half};
                `EBL_REG_CONTROL: next_st.rdata = 32'h0;
                default: begin
                    next_st.rdata = 32'h0;
                    next_st.rresp = `EBL_RESP_SLVERR;
                end
            endcase
        end else if (st.rvalid && s_axi_rready_i) begin
            next_st.rvalid = 1'b0;
        end
        // Loader sequence: read command, zero address, then stream.
        case (st.state)
            ST_BOOT: begin
                start = 1'b1;
                tx = `EBL_EE_READ;
                next_st.idx = 9'h000;
                next_st.state = ST_CMD;
            end
            ST_CMD: begin
                if (byte_done) begin
                    start = 1'b1;
                    next_st.idx = st.idx + 9'h001;
                    if (st.idx == `EBL_ADDR_LAST) begin
                        next_st.idx = 9'h000;
                        next_st.state = ST_HDR;
                    end
                end
            end
            ST_HDR: begin
                if (byte_done) begin
                    start = 1'b1;
                    next_st.idx = st.idx + 9'h001;
                    if (st.idx == `EBL_HDR_CFG) begin
                        next_st.hdr0 = rx_byte;
                        next_st.half = spi_half(rx_byte);
                        if (rx_byte[`EBL_VER_MSB:`EBL_VER_LSB] !=
                            `EBL_VERSION) begin
                            start = 1'b0;
                            next_st.cs_n = 1'b1;
                            next_st.ver_err = 1'b1;
                            next_st.state = ST_ERR;
                        end
                    end else if (st.idx == `EBL_HDR_OFS) begin
                        next_st.hdr1 = rx_byte;
                    end else begin
                        next_st.hdr2 = rx_byte;
                        next_st.left = {rx_byte, 8'h00};
                        if (rx_byte == 8'h00) begin
                            start = 1'b0;
                            finish = 1'b1;
                        end else if ({1'b0, st.hdr1} <=
                            st.idx + 9'h001) begin
                            next_st.state = ST_COPY;
                        end else begin
                            next_st.state = ST_SKIP;
                        end
                    end
                end
            end
            ST_SKIP: begin
                if (byte_done) begin
                    start = 1'b1;
                    next_st.idx = st.idx + 9'h001;
                    if ({1'b0, st.hdr1} <= st.idx + 9'h001) begin
                        next_st.state = ST_COPY;
                    end
                end
            end
            ST_COPY: begin
                if (byte_done) begin
                    next_st.ld_we = 1'b1;
                    next_st.ld_data = rx_byte;
                    next_st.left = st.left - 16'h0001;
                    // Bytes past the 4 KB top cannot be kept, so stop.
                    if (st.left == 16'h0001 || st.wr_addr == `EBL_PRAM_LAST)
                    begin
                        finish = 1'b1;
                    end else begin
                        start = 1'b1;
                    end
                end
            end
            ST_RUN: begin
                next_st.core_rst = wdog_rst_i || restart;
                if (wdog_rst_i || restart) begin
                    next_st.cause = `EBL_CAUSE_OTHER;
                end
            end
            ST_ERR: next_st.state = ST_ERR;
            default: next_st.state = ST_BOOT;
        endcase
        if (start) begin
            next_st.busy = 1'b1;
            next_st.div_cnt = 6'h00;
            next_st.bit_cnt = 3'h0;
            next_st.sh_out = tx;
            next_st.mosi = tx[7];
            next_st.cs_n = 1'b0;
        end
        if (finish) begin
            next_st.cs_n = 1'b1;
            next_st.done = 1'b1;
            next_st.core_rst = 1'b0;
            next_st.state = ST_RUN;
        end
    end

    // State register; the core stays in reset until the load ends.
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            st <= '0;
            st.cause <= `EBL_CAUSE_POR;
            st.half <= half_calc(`EBL_CLK_KHZ, `EBL_SLOW_KHZ);
            st.cs_n <= 1'b1;
            st.core_rst <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign core_rst_o = st.core_rst;
    assign spi_sck_o = st.sck;
    assign spi_mosi_o = st.mosi;
    assign spi_cs_n_o = st.cs_n;
    assign s_axi_awready_o = !st.aw_got && !st.bvalid;
    assign s_axi_wready_o = !st.w_got && !st.bvalid;
    assign s_axi_bvalid_o = st.bvalid;
    assign s_axi_bresp_o = st.bresp;
    assign s_axi_arready_o = !st.rvalid;
    assign s_axi_rvalid_o = st.rvalid;
    assign s_axi_rdata_o = st.rdata;
    assign s_axi_rresp_o = st.rresp;

    // ************************************************************
    // Program memory and internal data memory
    // ************************************************************

    assign pram_hit = pram_addr_i <= `EBL_PRAM_TOP;

    // Code fetches and data moves share one port; both answer one
    // clock later, and the core paces its own cycles on that.
    always_ff @(posedge clock_i) begin
        if (st.ld_we) begin
            pram_mem[st.wr_addr] <= st.ld_data;
        end else if (pram_we_i && pram_hit && !st.core_rst) begin
            pram_mem[pram_addr_i[11:0]] <= pram_wdata_i;
        end
        if (srst_i) begin
            pram_rdata_o <= 8'h00;
            pram_hit_o <= 1'b0;
        end else begin
            pram_rdata_o <= pram_mem[pram_addr_i[11:0]];
            pram_hit_o <= pram_hit;
        end
    end

    // Address decode: banked registers, bit addresses and the split
    // upper half, so the core sees the standard memory effects.
    assign eff_addr = idata_reg_i ? {3'h0,
        program_status_word_i[`EBL_BANK_MSB:`EBL_BANK_LSB],
        idata_addr_i[2:0]} :
        idata_bit_i ? bit_byte(idata_addr_i) : idata_addr_i;
    assign sfr_sel_o = !idata_indirect_i && eff_addr[7];
    assign sfr_addr_o = eff_addr;
    assign sfr_bit_o = idata_addr_i[2:0];

    // Bit writes change one bit only, as the standard core does.
    always_ff @(posedge clock_i) begin
        if (idata_we_i && !sfr_sel_o) begin
            if (idata_bit_i) begin
                iram[eff_addr][idata_addr_i[2:0]] <= idata_wdata_i[0];
            end else begin
                iram[eff_addr] <= idata_wdata_i;
            end
        end
        if (srst_i) begin
            idata_rdata_o <= 8'h00;
        end else if (idata_bit_i) begin
            idata_rdata_o <= {7'h0, iram[eff_addr][idata_addr_i[2:0]]};
        end else begin
            idata_rdata_o <= iram[eff_addr];
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    a_hold_until_loaded: assert property (!st.done |-> core_rst_o)
        else $error("Core released before the load ended.");
    a_bus_idle_run: assert property (
        st.state == ST_RUN |-> spi_cs_n_o)
        else $error("EEPROM selected after the load.");
    a_sck_high_min: assert property (
        $rose(spi_sck_o) |-> spi_sck_o [*2])
        else $error("Serial clock high phase too short.");
    a_divider_set: assert property (
        st.state == ST_HDR && byte_done &&
        st.idx == `EBL_HDR_CFG |=> st.half == spi_half($past(rx_byte)))
        else $error("Divider not taken from the header.");
    a_version_stop: assert property (
        st.state == ST_HDR && byte_done &&
        st.idx == `EBL_HDR_CFG && rx_byte[7:6] != `EBL_VERSION
        |=> st.state == ST_ERR && spi_cs_n_o)
        else $error("Unknown image version not refused.");
    a_block_count: assert property (
        st.state == ST_HDR && byte_done &&
        st.idx == `EBL_ADDR_LAST |=> st.left == {$past(rx_byte), 8'h00})
        else $error("Block count not loaded.");
    a_first_at_zero: assert property (st.state != ST_COPY ##1
        st.state == ST_COPY |-> st.wr_addr == 12'h000)
        else $error("First program byte not at zero.");
    a_skip_no_write: assert property (
        st.state inside {ST_CMD, ST_HDR,
        ST_SKIP} |-> !st.ld_we)
        else $error("Header or user data written.");
    a_wdog_no_reload: assert property (
        st.state == ST_RUN && wdog_rst_i
        |=> st.state == ST_RUN && core_rst_o && spi_cs_n_o)
        else $error("Watchdog restart misbehaved.");
    a_direct_sfr: assert property (
        !idata_indirect_i && !idata_reg_i &&
        !idata_bit_i && idata_addr_i[7] |-> sfr_sel_o)
        else $error("Direct upper access missed the registers.");
    a_indirect_ram: assert property (idata_indirect_i |-> !sfr_sel_o)
        else $error("Indirect access reached the registers.");

    c_load_done: cover property ($rose(st.done));
    c_version_err: cover property ($rose(st.ver_err));
    c_wdog_restart: cover property (st.state == ST_RUN && wdog_rst_i);
    c_sfr_bit: cover property (idata_bit_i && sfr_sel_o);
endmodule
`default_nettype wire

/* File: verif/ebl_eeprom_model.sv */
// Behavioural serial EEPROM that streams its image after a read command.
`timescale 1ns/1ps
`default_nettype none
module ebl_eeprom_model (
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    output logic miso_o
);
    // Header bytes 0..2, then user data and the program image.
    logic [7:0] mem [0:1023];
    logic [23:0] cmd = 24'h000000;
    int k = 0;
    initial miso_o = 1'b0;
    // A new select restarts the bit count; falls of the clock advance it.
    always @(negedge cs_n_i) k = 0;
    always @(negedge sck_i) if (!cs_n_i) k++;
    // Command and address bits are kept for the bench to inspect.
    always @(posedge sck_i) if (!cs_n_i && k < 24) cmd = {cmd[22:0], mosi_i};
    // Deselected, the line toggles so a stale value is never mistaken for data.
    always @(k or cs_n_i) miso_o = cs_n_i ? ~miso_o : (k < 24 ? k[0] :
        mem[(k - 24) / 8][7 - (k - 24) % 8]);
endmodule
`default_nettype wire

/* File: verif/eeprom_boot_loader_memory_map_tb.sv */
// Self-checking bench of the boot loader and memory map.
`timescale 1ns/1ps
`default_nettype none
module eeprom_boot_loader_memory_map_tb;
    import ebl_pkg::*;
    logic clock_i = 0, srst = 1, wdog = 0, we = 0, ind = 0, rg = 0, bt = 0;
    logic iwe = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic [15:0] pa = 16'h0000;
    logic [7:0] ia = 8'h00, iw = 8'h00, program_status_word = 8'h00, pw = 8'h00, awa = 8'h00;
    logic [7:0] ara = 8'h00, d, n;
    logic [31:0] wd = 32'h00000000, rd;
    logic [1:0] r;
    logic h;
    wire core_rst, sck, mosi, cs_n, miso, hit, ssel, awr, wr, bv, arr, rv;
    wire ebl_byte_t prd, idr;
    wire [7:0] saddr;
    wire [2:0] sbit;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int bad_count = 0, checked = 0, cyc = 0, c, i, x, l;
    int exp_q[$];
    ebl_loader ebl_loader_i (.clock_i(clock_i), .srst_i(srst),
        .wdog_rst_i(wdog), .core_rst_o(core_rst), .spi_sck_o(sck),
        .spi_mosi_o(mosi), .spi_cs_n_o(cs_n), .spi_miso_i(miso),
        .pram_addr_i(pa), .pram_we_i(we), .pram_wdata_i(pw),
        .pram_rdata_o(prd), .pram_hit_o(hit), .idata_addr_i(ia),
        .idata_indirect_i(ind), .idata_reg_i(rg), .idata_bit_i(bt),
        .idata_we_i(iwe), .idata_wdata_i(iw), .program_status_word_i(program_status_word),
        .idata_rdata_o(idr), .sfr_sel_o(ssel), .sfr_addr_o(saddr),
        .sfr_bit_o(sbit), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_araddr_i(ara),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry));
    ebl_eeprom_model ebl_eeprom_model_i (.sck_i(sck), .cs_n_i(cs_n),
        .mosi_i(mosi), .miso_o(miso));
    // ***************************************************************
    // Stimulus and checks
    // ***************************************************************
    initial forever #20 clock_i = ~clock_i;
    // A hang is cut short well above the expected run length.
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 90000) begin
            bad_count++;
            tally_and_finish;
        end
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // Both halves are offered together and each is dropped once taken.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        int k;
        @(posedge clock_i);
        awa <= a; wd <= v; awv <= 1; wv <= 1; bry <= 1; k = 0;
        do begin
            @(posedge clock_i);
            k++;
            if (awr) awv <= 0;
            if (wr) wv <= 0;
        end while (!bv);
        r = bresp;
        bry <= 0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
            input logic [1:0] er);
        int k;
        @(posedge clock_i);
        ara <= a; arv <= 1; rry <= 1; k = 0;
        do begin
            @(posedge clock_i);
            k++;
            if (arr) arv <= 0;
        end while (!rv);
        rd = rdata;
        r = rresp;
        rry <= 0;
        chk(rd, e);
        chk(r, er);
    endtask
    task automatic pr(input logic [15:0] a);
        @(posedge clock_i);
        pa <= a;
        @(posedge clock_i);
        #1 d = prd;
        h = hit;
    endtask
    task automatic id(input logic [7:0] a, input logic i1, input logic r1,
            input logic b1, input logic w1, input logic [7:0] v);
        @(posedge clock_i);
        ia <= a; ind <= i1; rg <= r1; bt <= b1; iwe <= w1; iw <= v;
        @(posedge clock_i);
        iwe <= 0;
        #1 d = idr;
    endtask
    // The model image and the expected program come from the same bytes.
    task automatic load(input logic [7:0] cfg, input logic [7:0] ofs,
            input logic [7:0] blk, input int lim);
        int j, k;
        exp_q = {};
        for (k = 3; k < 1024; k++) ebl_eeprom_model_i.mem[k] = $urandom;
        ebl_eeprom_model_i.mem[0] = cfg;
        ebl_eeprom_model_i.mem[1] = ofs;
        ebl_eeprom_model_i.mem[2] = blk;
        j = ofs < 3 ? 3 : ofs;
        for (k = 0; k < blk * 256; k++) begin
            exp_q.push_back(ebl_eeprom_model_i.mem[j + k]);
        end
        @(posedge clock_i);
        srst <= 1;
        repeat (5) @(posedge clock_i);
        srst <= 0;
        k = 0;
        do begin
            @(posedge clock_i);
            k++;
        end while (core_rst && k < lim);
    endtask
    initial begin
        void'($urandom(46765));
        for (c = 0; c < 8; c++) if (c < 5 || c == 7) begin
            load({4'h0, c[0], c[2:0]}, 8'h03, 8'h00, 20000);
            x = 4000 * (c > 4 ? 5 : c + 1);
            l = c[0] ? 1000 : 500;
            x = (x + 2 * l - 1) / (2 * l);
            chk(ebl_eeprom_model_i.cmd, 24'h030000);
            rdchk(8'h0C, x, 2'h0);
            rdchk(8'h04, {16'h0003, 4'h0, c[0], c[2:0]}, 2'h0);
            rdchk(8'h00, 32'h1, 2'h0);
        end
        $display("header decode done");
        load(8'h08, 8'h05, 8'h01, 30000);
        rdchk(8'h04, 32'h00010508, 2'h0);
        for (i = 0; i < 256; i++) begin
            pr(i[15:0]);
            chk(d, exp_q[i]);
        end
        chk(h, 1'b1);
        pr(16'h1000);
        chk(h, 1'b0);
        n = $urandom;
        @(posedge clock_i);
        pa <= 16'h0123; pw <= n; we <= 1;
        @(posedge clock_i);
        we <= 0;
        pr(16'h0123);
        chk(d, n);
        $display("program copy done");
        @(posedge clock_i);
        wdog <= 1;
        @(posedge clock_i);
        wdog <= 0;
        #1 chk(core_rst, 1'b1);
        @(posedge clock_i);
        #1 chk(core_rst, 1'b0);
        chk(cs_n, 1'b1);
        pr(16'h0123);
        chk(d, n);
        rdchk(8'h00, 32'h5, 2'h0);
        axi_wr(8'h08, 32'h1);
        chk(r, 2'h0);
        axi_wr(8'h20, 32'h1);
        chk(r, 2'h2);
        rdchk(8'h10, 32'h0, 2'h2);
        $display("restart done");
        id(8'h21, 0, 0, 0, 1, 8'h00);
        id(8'h0A, 0, 0, 1, 1, 8'h01);
        id(8'h21, 1, 0, 0, 0, 8'h00);
        chk(d, 8'h04);
        @(posedge clock_i);
        program_status_word <= 8'h10;
        id(8'h03, 0, 1, 0, 1, 8'h5A);
        id(8'h13, 0, 0, 0, 0, 8'h00);
        chk(d, 8'h5A);
        id(8'h90, 1, 0, 0, 1, 8'hC3);
        chk(ssel, 1'b0);
        id(8'h90, 1, 0, 0, 0, 8'h00);
        chk(d, 8'hC3);
        id(8'h90, 0, 0, 0, 0, 8'h00);
        chk({ssel, saddr}, 9'h190);
        id(8'h8B, 0, 0, 1, 0, 8'h00);
        chk({ssel, saddr, sbit}, 12'hC43);
        $display("data memory done");
        load(8'h40, 8'h03, 8'h00, 3000);
        chk(core_rst, 1'b1);
        rdchk(8'h00, 32'h2, 2'h0);
        $display("version refusal done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
